/* File: rtl/clock_switch_ctrl.sv */
// Clock source selection, switch handshake and register file
//
// Operation
// - Reset config 110 starts fast oscillator at 1 MHz, 000 at 32 MHz.
// - Divider request divides selected source from 1:1 to 1:512.
// - Doubler accepts only 8, 12 or 16 MHz, giving 16, 24, 32 MHz.
// - Reset config 000 loads frequency select 110 and enables doubler.
// - Trim resets to 00h, six-bit two's complement value.
// - Trim acts only on the fast oscillator, never the slow one.
// - Trim writes take effect silently; no completion status exists.
// - Slow oscillator always runs for timers; it is also selectable.
// - Ready status per oscillator; manual enables start each one, the doubler only at an accepted input frequency.
// - Old clock keeps running until requested source is ready; a wake with hold clear switches without checking ready.
// - A source already running, or divider-only change, is ready at once.
// - On ready set new-source-ready and interrupt flag; irq if enabled.
// - Hold clear: switch once the new source is ready and both source clocks are low.
// - In core_slowdown_mode the switch happens on the next clock regardless.
// - Current fields update at the switch; ready set, new-ready cleared.
// - Doubler input set by frequency select, then held by current source.
// - Doubler input change suspends operation until relock.
// - Sleep before the switch completes skips the switch.
// - Wake with hold clear resumes on new clock, sets interrupt flag.
// - Wake with hold set resumes on old clock, requests again.
// - Clock-out config picks clock output or other use of pin.
// - Reserved source code selects the fast internal oscillator.
// - Request: source in bits 6-4, divider 3-0, bit 7 reads zero.
// - With switching disallowed the request register is read-only.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
`include "clksw_consts.svh"
module clock_switch_ctrl #(
  parameter int SRC_N = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration straps
  input wire logic [2:0] reset_source_cfg,
  input wire logic switch_allow_cfg,
  input wire logic clock_out_enable_cfg,
  // Core power modes
  input wire logic sleep_active,
  input wire logic core_slowdown_mode,
  // Oscillator status and clock levels by source code
  input wire logic [5:0] osc_ready_in,
  input wire logic [SRC_N-1:0] src_level,
  // Oscillator control
  output logic [5:0] osc_enable,
  output logic [2:0] fast_internal_freq_sel,
  output logic [2:0] doubler_in_freq,
  output logic [5:0] fast_osc_trim,
  // System clock and core control
  output logic sys_clk_level,
  output logic cpu_suspend,
  output logic switch_irq,
  // Second oscillator pin
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic osc2_pin_out,
  output logic osc2_pin_oe
);
  clksw_pkg::sw_state_t state;
  logic cfg_loaded;
  logic [2:0] source_request;
  logic [3:0] divider_request;
  logic [2:0] current_source;
  logic [3:0] current_divider;
  logic switch_hold;
  logic osc_ready_flag;
  logic new_source_ready;
  logic switch_irq_flag;
  logic switch_irq_enable;
  logic [5:0] osc_manual_enable;
  logic [5:0] internal_osc_trim;
  logic wr;
  logic rd;
  logic pending;
  logic req_ready;
  logic mux_safe;
  logic pll_change;
  logic do_switch;
  logic mux_level;
  logic wake_switch;

  if (SRC_N != 8) begin : g_bad_src_n
    $error("SRC_N must be 8, one level per source code");
  end

  function automatic logic [2:0] legal_src(input logic [2:0] code);
    if (code == 3'h2 || code == 3'h3) begin
      return `CLKSW_SRC_HF;
    end
    return code;
  endfunction : legal_src

  function automatic logic [5:0] src_needs(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      `CLKSW_SRC_HF_PLL: m = 6'h22;
      `CLKSW_SRC_EXT_PLL: m = 6'h11;
      `CLKSW_SRC_SECONDARY_OSC: m = 6'h08;
      `CLKSW_SRC_LF: m = 6'h04;
      `CLKSW_SRC_EXT: m = 6'h01;
      default: m = 6'h02;
    endcase
    return m;
  endfunction : src_needs

  function automatic logic doubler_ok(input logic [2:0] frq);
    return frq == `CLKSW_FRQ_8MHZ || frq == `CLKSW_FRQ_12MHZ ||
      frq == `CLKSW_FRQ_16MHZ;
  endfunction : doubler_ok

  function automatic logic [2:0] strap_freq(input logic [2:0] cfg);
    return (cfg == `CLKSW_SRC_HF_PLL) ? `CLKSW_FRQ_16MHZ : `CLKSW_FRQ_4MHZ;
  endfunction : strap_freq

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pending = (source_request != current_source) ||
    (divider_request != current_divider);
  assign req_ready = (source_request == current_source) ||
    ((src_needs(source_request) & osc_ready_in) ==
      src_needs(source_request));
  assign mux_safe = !src_level[current_source] &&
    !src_level[source_request];
  assign pll_change = current_source == `CLKSW_SRC_HF_PLL &&
    source_request == `CLKSW_SRC_HF_PLL &&
    fast_internal_freq_sel != doubler_in_freq;
  // no wait for both source clocks low in core_slowdown_mode
  assign do_switch = cfg_loaded && !sleep_active && !switch_hold &&
    ((state == clksw_pkg::ST_READY && !pll_change &&
      (mux_safe || core_slowdown_mode)) ||
     (state == clksw_pkg::ST_RELOCK &&
      osc_ready_in[`CLKSW_OSC_PLL2]));
  // wake completes a switch that sleep cut short
  assign wake_switch = state == clksw_pkg::ST_SLEEP && !sleep_active &&
    !switch_hold && pending;

  // Handshake state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= clksw_pkg::ST_IDLE;
    end else if (!cfg_loaded) begin
      state <= clksw_pkg::ST_IDLE;
    end else begin
      unique case (state)
        clksw_pkg::ST_IDLE: begin
          if (pending && !sleep_active) begin
            state <= clksw_pkg::ST_WAIT;
          end
        end
        clksw_pkg::ST_WAIT: begin
          if (sleep_active) begin
            state <= clksw_pkg::ST_SLEEP;
          end else if (!pending) begin
            state <= clksw_pkg::ST_IDLE;
          end else if (req_ready) begin
            state <= clksw_pkg::ST_READY;
          end
        end
        clksw_pkg::ST_READY: begin
          if (sleep_active) begin
            state <= clksw_pkg::ST_SLEEP;
          end else if (!pending) begin
            state <= clksw_pkg::ST_IDLE;
          end else if (!switch_hold && pll_change) begin
            state <= clksw_pkg::ST_RELOCK;
          end else if (do_switch) begin
            state <= clksw_pkg::ST_IDLE;
          end
        end
        clksw_pkg::ST_RELOCK: begin
          if (do_switch) begin
            state <= clksw_pkg::ST_IDLE;
          end
        end
        clksw_pkg::ST_SLEEP: begin
          if (!sleep_active) begin
            state <= (pending && switch_hold) ? clksw_pkg::ST_WAIT :
              clksw_pkg::ST_IDLE;
          end
        end
        default: state <= clksw_pkg::ST_IDLE;
      endcase
    end
  end

  // Request register, loaded from straps after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded <= 1'b0;
      source_request <= `CLKSW_SRC_HF;
      divider_request <= `CLKSW_DIV_1;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      source_request <= legal_src(reset_source_cfg);
      divider_request <= (reset_source_cfg == `CLKSW_SRC_HF) ?
        `CLKSW_DIV_4 : `CLKSW_DIV_1;
    end else if (wr && paddr == `CLKSW_OFS_REQUEST && switch_allow_cfg) begin
      source_request <= legal_src(pwdata[6:4]);
      divider_request <= pwdata[3:0];
    end
  end

  // Current selection, loaded from straps, then changes only at the switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_source <= `CLKSW_SRC_HF;
      current_divider <= `CLKSW_DIV_1;
    end else if (!cfg_loaded) begin
      current_source <= legal_src(reset_source_cfg);
      current_divider <= (reset_source_cfg == `CLKSW_SRC_HF) ?
        `CLKSW_DIV_4 : `CLKSW_DIV_1;
    end else if (do_switch || wake_switch) begin
      current_source <= source_request;
      current_divider <= divider_request;
    end
  end

  // Status flags; hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ready_flag <= 1'b0;
      new_source_ready <= 1'b0;
    end else if (!cfg_loaded) begin
      osc_ready_flag <= 1'b1;
      new_source_ready <= 1'b0;
    end else if (do_switch || wake_switch) begin
      osc_ready_flag <= 1'b1;
      new_source_ready <= 1'b0;
    end else if (state == clksw_pkg::ST_WAIT && req_ready && pending &&
        !sleep_active) begin
      new_source_ready <= 1'b1;
    end else if (pending) begin
      osc_ready_flag <= 1'b0;
    end else begin
      new_source_ready <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_irq_flag <= 1'b0;
    end else if ((state == clksw_pkg::ST_WAIT && req_ready && pending &&
        !sleep_active) || wake_switch) begin
      switch_irq_flag <= 1'b1;
    end else if (wr && paddr == `CLKSW_OFS_IRQ &&
        pwdata[`CLKSW_BIT_IRQ_FLAG]) begin
      switch_irq_flag <= 1'b0;
    end
  end

  // Software control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_hold <= 1'b0;
      switch_irq_enable <= 1'b0;
      osc_manual_enable <= 6'h00;
      fast_internal_freq_sel <= `CLKSW_FRQ_4MHZ;
      internal_osc_trim <= `CLKSW_TRIM_RESET;
    end else if (!cfg_loaded) begin
      fast_internal_freq_sel <= strap_freq(reset_source_cfg);
    end else if (wr) begin
      if (paddr == `CLKSW_OFS_STATUS) begin
        switch_hold <= pwdata[`CLKSW_BIT_HOLD];
      end
      if (paddr == `CLKSW_OFS_IRQ) begin
        switch_irq_enable <= pwdata[`CLKSW_BIT_IRQ_EN];
      end
      if (paddr == `CLKSW_OFS_MANUAL) begin
        osc_manual_enable <= pwdata[5:0];
      end
      if (paddr == `CLKSW_OFS_FREQ) begin
        fast_internal_freq_sel <= pwdata[2:0];
      end
      if (paddr == `CLKSW_OFS_TRIM) begin
        internal_osc_trim <= pwdata[5:0];
      end
    end
  end

  // doubler input held by current source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doubler_in_freq <= `CLKSW_FRQ_16MHZ;
    end else if (!cfg_loaded) begin
      // strap value, the select register is still stale here
      doubler_in_freq <= strap_freq(reset_source_cfg);
    end else if (current_source != `CLKSW_SRC_HF_PLL ||
        state == clksw_pkg::ST_RELOCK) begin
      doubler_in_freq <= fast_internal_freq_sel;
    end
  end

  always_comb begin
    osc_enable = osc_manual_enable;
    if (!sleep_active) begin
      osc_enable = osc_enable | src_needs(current_source);
      if (pending) begin
        osc_enable = osc_enable | src_needs(source_request);
      end
    end
    osc_enable[`CLKSW_OSC_LF] = 1'b1;
    if (!doubler_ok(doubler_in_freq)) begin
      osc_enable[`CLKSW_OSC_PLL2] = 1'b0;
    end
  end

  // trim goes to fast oscillator only
  assign fast_osc_trim = internal_osc_trim;
  assign cpu_suspend = state == clksw_pkg::ST_RELOCK;
  assign switch_irq = switch_irq_flag && switch_irq_enable;
  assign mux_level = src_level[current_source];

  clock_postdivider #(
    .CNT_W(9)
  ) u_postdiv (
    .pclk(pclk),
    .presetn(presetn),
    .src_level(mux_level),
    .ratio(current_divider),
    .div_level(sys_clk_level)
  );

  assign osc2_pin_out = clock_out_enable_cfg ? sys_clk_level : gpio_out;
  assign osc2_pin_oe = clock_out_enable_cfg ? 1'b1 : gpio_oe;

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd) begin
      unique case (paddr)
        `CLKSW_OFS_REQUEST: prdata[6:0] = {source_request, divider_request};
        `CLKSW_OFS_CURRENT: prdata[6:0] = {current_source, current_divider};
        `CLKSW_OFS_STATUS: begin
          prdata[`CLKSW_BIT_HOLD] = switch_hold;
          prdata[`CLKSW_BIT_OSC_READY_FLAG] = osc_ready_flag;
          prdata[`CLKSW_BIT_NEW_SOURCE_READY] = new_source_ready;
        end
        `CLKSW_OFS_READY: prdata[5:0] = osc_ready_in;
        `CLKSW_OFS_MANUAL: prdata[5:0] = osc_manual_enable;
        `CLKSW_OFS_FREQ: prdata[2:0] = fast_internal_freq_sel;
        `CLKSW_OFS_TRIM: prdata[5:0] = internal_osc_trim;
        `CLKSW_OFS_IRQ: prdata[1:0] = {switch_irq_enable, switch_irq_flag};
        default: pslverr = 1'b1;
      endcase
    end else if (psel && (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0)) begin
      pslverr = 1'b1;
    end
  end

  property p_locked_request;
    @(posedge pclk) disable iff (!presetn)
    cfg_loaded && !switch_allow_cfg |=> $stable(source_request) &&
      $stable(divider_request);
  endproperty
  a_locked_request: assert property (p_locked_request)
    else $error("request changed while switching disallowed");

  property p_no_reserved;
    @(posedge pclk) disable iff (!presetn)
    source_request != 3'h2 && source_request != 3'h3;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved source code held in request");

  property p_current_stable;
    @(posedge pclk) disable iff (!presetn)
    cfg_loaded && !do_switch && !(state == clksw_pkg::ST_SLEEP &&
      !sleep_active) |=> $stable(current_source);
  endproperty
  a_current_stable: assert property (p_current_stable)
    else $error("current source changed without a switch");

  property p_switch_flags;
    @(posedge pclk) disable iff (!presetn)
    do_switch |=> osc_ready_flag && !new_source_ready &&
      current_source == $past(source_request);
  endproperty
  a_switch_flags: assert property (p_switch_flags)
    else $error("switch did not update current fields and flags");

  property p_hold_blocks;
    @(posedge pclk) disable iff (!presetn)
    switch_hold |-> !do_switch;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("switch performed while hold set");

  property p_ready_irq;
    @(posedge pclk) disable iff (!presetn)
    state == clksw_pkg::ST_WAIT && req_ready && pending && !sleep_active
      |=> new_source_ready && switch_irq_flag;
  endproperty
  a_ready_irq: assert property (p_ready_irq)
    else $error("ready did not set flags");

  property p_sleep_no_switch;
    @(posedge pclk) disable iff (!presetn)
    sleep_active |-> !do_switch;
  endproperty
  a_sleep_no_switch: assert property (p_sleep_no_switch)
    else $error("switch performed in sleep");

  property p_lf_on;
    @(posedge pclk) disable iff (!presetn)
    osc_enable[`CLKSW_OSC_LF];
  endproperty
  a_lf_on: assert property (p_lf_on)
    else $error("slow oscillator disabled");

  property p_glitch_free;
    @(posedge pclk) disable iff (!presetn)
    do_switch && state == clksw_pkg::ST_READY && !core_slowdown_mode
      |-> !src_level[current_source] && !src_level[source_request];
  endproperty
  a_glitch_free: assert property (p_glitch_free)
    else $error("mux switched while a clock was high");

  property p_relock_suspend;
    @(posedge pclk) disable iff (!presetn)
    state == clksw_pkg::ST_RELOCK |-> cpu_suspend;
  endproperty
  a_relock_suspend: assert property (p_relock_suspend)
    else $error("cpu not suspended during relock");

  c_switch: cover property (@(posedge pclk) disable iff (!presetn)
    do_switch);
  c_relock: cover property (@(posedge pclk) disable iff (!presetn)
    state == clksw_pkg::ST_RELOCK ##1 state == clksw_pkg::ST_IDLE);
  c_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn)
    state == clksw_pkg::ST_SLEEP ##1 !sleep_active);
endmodule : clock_switch_ctrl

/* File: common/clksw_consts.svh */
// Offsets, field positions, codes and reset values of the clock switch block
`ifndef CLKSW_CONSTS_SVH
`define CLKSW_CONSTS_SVH
`define CLKSW_OFS_REQUEST 8'h00
`define CLKSW_OFS_CURRENT 8'h04
`define CLKSW_OFS_STATUS 8'h08
`define CLKSW_OFS_READY 8'h0C
`define CLKSW_OFS_MANUAL 8'h10
`define CLKSW_OFS_FREQ 8'h14
`define CLKSW_OFS_TRIM 8'h18
`define CLKSW_OFS_IRQ 8'h1C
`define CLKSW_SRC_HF_PLL 3'h0
`define CLKSW_SRC_EXT_PLL 3'h1
`define CLKSW_SRC_SECONDARY_OSC 3'h4
`define CLKSW_SRC_LF 3'h5
`define CLKSW_SRC_HF 3'h6
`define CLKSW_SRC_EXT 3'h7
`define CLKSW_DIV_1 4'h0
`define CLKSW_DIV_4 4'h2
`define CLKSW_DIV_MAX 4'h9
`define CLKSW_FRQ_4MHZ 3'h2
`define CLKSW_FRQ_8MHZ 3'h3
`define CLKSW_FRQ_12MHZ 3'h4
`define CLKSW_FRQ_16MHZ 3'h6
`define CLKSW_TRIM_RESET 6'h00
`define CLKSW_BIT_HOLD 7
`define CLKSW_BIT_OSC_READY_FLAG 4
`define CLKSW_BIT_NEW_SOURCE_READY 3
`define CLKSW_BIT_IRQ_FLAG 0
`define CLKSW_BIT_IRQ_EN 1
`define CLKSW_OSC_EXT 0
`define CLKSW_OSC_HF 1
`define CLKSW_OSC_LF 2
`define CLKSW_OSC_SECONDARY_OSC 3
`define CLKSW_OSC_PLL4 4
`define CLKSW_OSC_PLL2 5
`endif

/* File: common/clksw_pkg.sv */
// Types shared by the clock switch block
package clksw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_READY = 3'h3,
    ST_RELOCK = 3'h2,
    ST_SLEEP = 3'h6
  } sw_state_t;
endpackage : clksw_pkg

/* File: rtl/clock_postdivider.sv */
// Power-of-two post-divider of the selected source clock level
`timescale 1ns/10ps
`include "clksw_consts.svh"
module clock_postdivider #(
  parameter int CNT_W = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source and ratio
  input wire logic src_level,
  input wire logic [3:0] ratio,
  // Divided clock
  output logic div_level
);
  logic src_q;
  logic [CNT_W-1:0] cnt;
  logic [3:0] eff;

  if (CNT_W != 9) begin : g_bad_cnt_w
    $error("CNT_W must be 9 for ratios up to 1:512");
  end

  assign eff = (ratio > `CLKSW_DIV_MAX) ? `CLKSW_DIV_MAX : ratio;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
      cnt <= '0;
    end else begin
      src_q <= src_level;
      if (src_level && !src_q) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_level <= 1'b0;
    end else if (eff == `CLKSW_DIV_1) begin
      div_level <= src_q;
    end else begin
      div_level <= cnt[eff-4'h1];
    end
  end
endmodule : clock_postdivider

/* File: verification/tb_clock_switch_ctrl.sv */
// Self-checking bench for the clock switch controller over APB
`timescale 1ns/10ps
`include "clksw_consts.svh"
module tb_clock_switch_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] reset_source_cfg, fast_internal_freq_sel, doubler_in_freq;
  logic switch_allow_cfg, clock_out_enable_cfg;
  logic sleep_active, core_slowdown_mode;
  logic [5:0] osc_ready_in, osc_enable, fast_osc_trim;
  logic [7:0] src_level;
  logic sys_clk_level, cpu_suspend, switch_irq, gpio_out, gpio_oe;
  logic osc2_pin_out, osc2_pin_oe;
  logic src_hold;
  int bad_count, comparisons, cyc;

  clock_switch_ctrl u_clock_switch_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .reset_source_cfg(reset_source_cfg), .switch_allow_cfg(switch_allow_cfg),
    .clock_out_enable_cfg(clock_out_enable_cfg),
    .sleep_active(sleep_active), .core_slowdown_mode(core_slowdown_mode),
    .osc_ready_in(osc_ready_in), .src_level(src_level),
    .osc_enable(osc_enable), .fast_internal_freq_sel(fast_internal_freq_sel),
    .doubler_in_freq(doubler_in_freq), .fast_osc_trim(fast_osc_trim),
    .sys_clk_level(sys_clk_level), .cpu_suspend(cpu_suspend),
    .switch_irq(switch_irq), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .osc2_pin_out(osc2_pin_out), .osc2_pin_oe(osc2_pin_oe)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // All source clocks share one slow phase, so a both-low point recurs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    src_level <= src_hold ? 8'hFF : {8{cyc[2]}};
    if (cyc == 20000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready under a bound, idle cycle after
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t no pready", $time);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask : rd

  // Polls the current source register until it shows the expected value
  task wait_cur(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      xfer(1'b0, `CLKSW_OFS_CURRENT, 32'h0);
      n++;
    end while (rdv !== e && n < 40);
    chk(rdv, e);
  endtask : wait_cur

  // Rising edges of the system clock over 128 cycles, a whole period count
  task clk_edges(input int e);
    int n;
    logic p;
    n = 0;
    p = sys_clk_level;
    repeat (128) begin
      @(posedge pclk);
      if (sys_clk_level && !p) n++;
      p = sys_clk_level;
    end
    chk(n, e);
  endtask : clk_edges

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    comparisons = 0;
    src_hold = 1'b0;
    reset_source_cfg = 3'h6;
    switch_allow_cfg = 1'b1;
    clock_out_enable_cfg = 1'b0;
    sleep_active = 1'b0;
    core_slowdown_mode = 1'b0;
    osc_ready_in = 6'h3F;
    gpio_out = 1'b1;
    gpio_oe = 1'b0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(`CLKSW_OFS_REQUEST, 32'hFF, 32'h62);
    rd(`CLKSW_OFS_TRIM, 32'hFF, 32'h00);
    $display("reset values done");
    wr(`CLKSW_OFS_TRIM, 32'h1F);
    rd(`CLKSW_OFS_TRIM, 32'hFF, 32'h1F);
    wr(`CLKSW_OFS_TRIM, 32'h20);
    chk(fast_osc_trim, 6'h20);
    wr(`CLKSW_OFS_MANUAL, 32'h28);
    chk(osc_enable[3], 1'b1);
    chk(osc_enable[5], 1'b0);
    rd(`CLKSW_OFS_READY, 32'h3F, 32'h3F);
    $display("trim and enables done");
    wr(`CLKSW_OFS_IRQ, 32'h3);
    wr(`CLKSW_OFS_REQUEST, 32'h60);
    wait_cur(32'h60);
    chk(switch_irq, 1'b1);
    wr(`CLKSW_OFS_IRQ, 32'h3);
    rd(`CLKSW_OFS_IRQ, 32'h3, 32'h2);
    chk(switch_irq, 1'b0);
    $display("divider switch done");
    wr(`CLKSW_OFS_STATUS, 32'h80);
    wr(`CLKSW_OFS_REQUEST, 32'h50);
    repeat (12) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h60);
    rd(`CLKSW_OFS_STATUS, 32'h08, 32'h08);
    wr(`CLKSW_OFS_STATUS, 32'h00);
    wait_cur(32'h50);
    rd(`CLKSW_OFS_STATUS, 32'h18, 32'h10);
    $display("hold switch done");
    wr(`CLKSW_OFS_IRQ, 32'h1);
    osc_ready_in <= 6'h3E;
    wr(`CLKSW_OFS_REQUEST, 32'h70);
    repeat (6) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h50);
    sleep_active <= 1'b1;
    osc_ready_in <= 6'h3F;
    repeat (10) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h50);
    sleep_active <= 1'b0;
    wait_cur(32'h70);
    rd(`CLKSW_OFS_IRQ, 32'h1, 32'h1);
    rd(`CLKSW_OFS_STATUS, 32'h18, 32'h10);
    $display("sleep switch done");
    wr(`CLKSW_OFS_REQUEST, 32'h20);
    wait_cur(32'h60);
    switch_allow_cfg <= 1'b0;
    wr(`CLKSW_OFS_REQUEST, 32'h50);
    repeat (10) @(posedge pclk);
    rd(`CLKSW_OFS_REQUEST, 32'hF0, 32'h60);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h60);
    xfer(1'b0, 8'h20, 32'h0);
    chk(errv, 1'b1);
    $display("reserved and locked done");
    chk(osc2_pin_out, 1'b1);
    chk(osc2_pin_oe, 1'b0);
    clock_out_enable_cfg <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(osc2_pin_out, sys_clk_level);
    chk(osc2_pin_oe, 1'b1);
    $display("clock out done");
    switch_allow_cfg <= 1'b1;
    clk_edges(16);
    wr(`CLKSW_OFS_REQUEST, 32'h62);
    wait_cur(32'h62);
    repeat (40) @(posedge pclk);
    clk_edges(4);
    $display("divider ratio done");
    reset_source_cfg <= 3'h0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h00);
    rd(`CLKSW_OFS_FREQ, 32'h7, 32'h6);
    chk(fast_internal_freq_sel, 3'h6);
    chk(doubler_in_freq, 3'h6);
    chk(osc_enable[5], 1'b1);
    wr(`CLKSW_OFS_FREQ, 32'h3);
    osc_ready_in <= 6'h1F;
    wr(`CLKSW_OFS_REQUEST, 32'h01);
    repeat (6) @(posedge pclk);
    chk(cpu_suspend, 1'b1);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h00);
    osc_ready_in <= 6'h3F;
    wait_cur(32'h01);
    chk(doubler_in_freq, 3'h3);
    chk(cpu_suspend, 1'b0);
    $display("doubler relock done");
    wr(`CLKSW_OFS_STATUS, 32'h80);
    wr(`CLKSW_OFS_REQUEST, 32'h51);
    repeat (4) @(posedge pclk);
    sleep_active <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(`CLKSW_OFS_IRQ, 32'h1);
    sleep_active <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h01);
    rd(`CLKSW_OFS_IRQ, 32'h1, 32'h1);
    wr(`CLKSW_OFS_STATUS, 32'h00);
    wait_cur(32'h51);
    $display("hold across sleep done");
    src_hold <= 1'b1;
    wr(`CLKSW_OFS_REQUEST, 32'h50);
    repeat (12) @(posedge pclk);
    rd(`CLKSW_OFS_CURRENT, 32'hFF, 32'h51);
    core_slowdown_mode <= 1'b1;
    wait_cur(32'h50);
    core_slowdown_mode <= 1'b0;
    src_hold <= 1'b0;
    $display("core_slowdown_mode switch done");
    conclude();
  end
endmodule : tb_clock_switch_ctrl
